// ===== design/mme_consts.svh
`ifndef MME_CONSTS_SVH
`define MME_CONSTS_SVH

// Region layout: base reset value, then offsets relative to the region base
`define MME_BASE_RST 32'h0003_0000
`define MME_HANDLER_OFS 32'h0000_8000
`define MME_SAVE_LO 32'h0000_FE00
`define MME_SAVE_HI 32'h0000_FFFF
`define MME_REGION_SIZE 32'h0001_0000
`define MME_ALIGN_MASK 32'h0000_7FFF

// Register port offsets
`define MME_REG_BASE 4'h0
`define MME_REG_CTRL 4'h4
`define MME_REG_STAT 4'h8

// Control register fields
`define MME_CTRL_LEGACY 0
`define MME_CTRL_RST 32'h0000_0000

// Restored state fields
`define MME_CR0_PE 0
`define MME_CR0_NW 29
`define MME_CR0_CD 30
`define MME_CR0_PG 31
`define MME_CR4_CTXID 17
`define MME_EFER_LMA 10
`define MME_CR4_RSVD 32'hFF80_0000

`endif

// ===== design/mme_pkg.sv
package mme_pkg;

  typedef logic [31:0] mme_word_t;

  typedef enum logic [1:0] {
    MME_REAL = 2'h0,
    MME_PROT = 2'h1,
    MME_V86 = 2'h2
  } mme_opmode_e;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DRAIN = 7'h02,
    ST_SAVE = 7'h04,
    ST_HANDLER = 7'h08,
    ST_RESTORE = 7'h10,
    ST_CHECK = 7'h20,
    ST_SHUTDN = 7'h40
  } mme_state_e;

endpackage : mme_pkg

// ===== design/mme_chk_if.sv
`timescale 1ns/1ps
`default_nettype none

interface mme_chk_if;
  import mme_pkg::*;
  mme_word_t cr0;
  mme_word_t cr4;
  mme_word_t efer;
  mme_word_t base;
  logic legacy;
  logic bad;
  modport ctrl (output cr0, output cr4, output efer, output base, output legacy, input bad);
  modport chk (input cr0, input cr4, input efer, input base, input legacy, output bad);
endinterface : mme_chk_if

`default_nettype wire

// ===== design/mme_irq_sync.sv
`timescale 1ns/1ps
`default_nettype none

module mme_irq_sync (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic pin_n,
  input wire logic msg,
  input wire logic accept,
  input wire logic take,
  output logic pending
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic req;

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= pin_n;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Falling edge of the pin or a bus message
  assign req = (s3_r & ~s2_r) | msg;

  // Single latch: extra requests merge, set beats clear
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pending <= 1'b0;
    end else if (accept && req) begin
      pending <= 1'b1;
    end else if (take) begin
      pending <= 1'b0;
    end
  end
endmodule : mme_irq_sync

`default_nettype wire

// ===== design/mme_restore_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "mme_consts.svh"

module mme_restore_chk (
  mme_chk_if.chk c
);
  import mme_pkg::*;

  function automatic logic cr0_bad(input mme_word_t v);
    cr0_bad = (v[`MME_CR0_PG] && !v[`MME_CR0_PE]) || (v[`MME_CR0_NW] && !v[`MME_CR0_CD]);
  endfunction : cr0_bad

  logic cr4_bad;
  logic ctx_bad;
  logic align_bad;

  assign cr4_bad = |(c.cr4 & `MME_CR4_RSVD);
  assign ctx_bad = c.cr4[`MME_CR4_CTXID] && !c.efer[`MME_EFER_LMA];
  assign align_bad = c.legacy && (|(c.base & `MME_ALIGN_MASK));
  assign c.bad = cr4_bad || cr0_bad(c.cr0) || ctx_bad || align_bad;
endmodule : mme_restore_chk

`default_nettype wire

// ===== design/mme_ctrl.sv
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mme_consts.svh"

// Operation
// - Take request only at instruction boundary
// - Drain retirement and stores before saving
// - Handler fetch starts at base plus 8000h
// - Context saved within base+FE00h..base+FFFFh
// - Region base resets to 30000h
// - Region is 64 KBytes from base
// - Mode accesses stay below 4 GBytes
// - Entry: acknowledge pulse, flag, active pin
// - Management request beats NMI, MASKABLE_IRQ_IN, debug
// - No nesting; latch one later request
// - Resume only in mode, else invalid opcode
// - Resume reloads saved image, then returns
// - Exit: acknowledge, flag off, pin released
// - Bad restored state: shutdown plus bus cycle
// - Reserved control-four bit means shutdown
// - Bad paging/protect or cache combos shut down
// - Context ids without long mode shut down
// - Legacy only: unaligned base shuts down
// - Shutdown waits reset/init/NMI, inhibits MASKABLE_IRQ_IN, ADDR_BIT20_MASK
// - Entry only via pin or bus message
// - Resume restores real/protected/v86 mode
module mme_ctrl #(
  parameter int PA_W = 36,
  parameter int NWORDS = 4
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic MGMT_IRQ_N,
  input wire logic APIC_MGMT_MSG,
  input wire logic INSN_BOUNDARY,
  input wire logic RETIRED_ALL,
  input wire logic STORES_DONE,
  input wire logic NMI_REQ,
  input wire logic MASKABLE_IRQ_IN_REQ,
  input wire logic DBG_REQ,
  input wire logic INIT_REQ,
  input wire logic RESUME_EXEC,
  input wire mme_pkg::mme_word_t CUR_CR0,
  input wire mme_pkg::mme_word_t CUR_CR4,
  input wire mme_pkg::mme_word_t CUR_EFER,
  input wire mme_pkg::mme_opmode_e CUR_MODE,
  input wire mme_pkg::mme_word_t MEM_RDATA,
  input wire logic MEM_ACK,
  input wire logic [3:0] REG_ADDR,
  input wire mme_pkg::mme_word_t REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output mme_pkg::mme_word_t REG_RDATA,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [PA_W-1:0] MEM_ADDR,
  output mme_pkg::mme_word_t MEM_WDATA,
  output logic FETCH_REDIRECT,
  output logic [PA_W-1:0] FETCH_ADDR,
  output logic MGMT_ACTIVE_N,
  output logic MGMT_BUS_STATUS_FLAG,
  output logic MGMT_ACK_TRANSACTION,
  output logic [2:0] OTHER_GRANT,
  output logic INVALID_OPCODE_FAULT,
  output logic RESTORE_LOAD,
  output mme_pkg::mme_word_t RESTORE_CR0,
  output mme_pkg::mme_word_t RESTORE_CR4,
  output mme_pkg::mme_word_t RESTORE_EFER,
  output mme_pkg::mme_opmode_e RESTORE_MODE,
  output logic SHUTDOWN,
  output logic SHUTDOWN_CYCLE,
  output logic INHIBIT_MASKABLE_IRQ_IN,
  output logic INHIBIT_ADDR_BIT20_MASK
);
  import mme_pkg::*;

  localparam int IW = $clog2(NWORDS);

  mme_state_e st_r;
  mme_state_e st_nxt;
  logic [IW-1:0] idx_r;
  logic [IW-1:0] idx_nxt;
  mme_word_t base_r;
  mme_word_t ctrl_r;
  mme_word_t snap_cr0_r;
  mme_word_t snap_cr4_r;
  mme_word_t snap_efer_r;
  mme_opmode_e snap_mode_r;
  logic in_mode_r;
  logic in_mode_nxt;
  logic pend;
  logic accept;
  logic take_smi;
  logic last;
  logic drained;
  logic enter;
  logic resume_ok;
  logic resume_bad;
  logic leave_shut;

  mme_chk_if chk ();

  function automatic mme_word_t save_addr(input mme_word_t b, input logic [IW-1:0] i);
    save_addr = b + `MME_SAVE_LO + 32'({i, 2'b00});
  endfunction : save_addr

  // Zero-extend: nothing above 4 GBytes is reachable in mode
  function automatic logic [PA_W-1:0] phys(input mme_word_t a);
    phys = {{(PA_W-32){1'b0}}, a};
  endfunction : phys

  function automatic mme_word_t ctx_word(input logic [IW-1:0] i, input mme_word_t c0,
                                         input mme_word_t c4, input mme_word_t ef,
                                         input mme_opmode_e m);
    case (i)
      0: ctx_word = c0;
      1: ctx_word = c4;
      2: ctx_word = ef;
      default: ctx_word = 32'({m});
    endcase
  endfunction : ctx_word

  // Requests seen during drain, save or shutdown are not latched and are lost
  assign accept = (st_r == ST_IDLE) || (st_r == ST_HANDLER) ||
                  (st_r == ST_RESTORE) || (st_r == ST_CHECK);

  mme_irq_sync u_sync (
    .CLK(CLK),
    .RESETN(RESETN),
    .pin_n(MGMT_IRQ_N),
    .msg(APIC_MGMT_MSG),
    .accept(accept),
    .take(take_smi),
    .pending(pend)
  );

  assign chk.cr0 = RESTORE_CR0;
  assign chk.cr4 = RESTORE_CR4;
  assign chk.efer = RESTORE_EFER;
  assign chk.base = base_r;
  assign chk.legacy = ctrl_r[`MME_CTRL_LEGACY];

  mme_restore_chk u_chk (
    .c(chk.chk)
  );

  assign take_smi = (st_r == ST_IDLE) && INSN_BOUNDARY && pend;
  assign drained = RETIRED_ALL && STORES_DONE;
  assign last = (idx_r == IW'(NWORDS - 1));
  assign enter = (st_r == ST_SAVE) && MEM_ACK && last;
  assign resume_ok = (st_r == ST_CHECK) && !chk.bad;
  assign resume_bad = (st_r == ST_CHECK) && chk.bad;
  assign leave_shut = (st_r == ST_SHUTDN) && (NMI_REQ || INIT_REQ);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (take_smi) st_nxt = ST_DRAIN;
      end
      ST_DRAIN: begin
        if (drained) st_nxt = ST_SAVE;
      end
      ST_SAVE: begin
        if (MEM_ACK && last) st_nxt = ST_HANDLER;
      end
      ST_HANDLER: begin
        if (RESUME_EXEC) st_nxt = ST_RESTORE;
      end
      ST_RESTORE: begin
        if (MEM_ACK && last) st_nxt = ST_CHECK;
      end
      ST_CHECK: begin
        st_nxt = chk.bad ? ST_SHUTDN : ST_IDLE;
      end
      ST_SHUTDN: begin
        if (NMI_REQ || INIT_REQ) st_nxt = ST_IDLE;
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    idx_nxt = idx_r;
    if (st_r != st_nxt) begin
      idx_nxt = '0;
    end else if (MEM_ACK && !last) begin
      idx_nxt = idx_r + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      idx_r <= '0;
    end else begin
      idx_r <= idx_nxt;
    end
  end

  // Snapshot at the drained boundary, so the image is the interrupted program
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      snap_cr0_r <= '0;
      snap_cr4_r <= '0;
      snap_efer_r <= '0;
      snap_mode_r <= MME_REAL;
    end else if ((st_r == ST_DRAIN) && drained) begin
      snap_cr0_r <= CUR_CR0;
      snap_cr4_r <= CUR_CR4;
      snap_efer_r <= CUR_EFER;
      snap_mode_r <= CUR_MODE;
    end
  end

  // Request held through the save and restore states; one word per acknowledge
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      MEM_REQ <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_ADDR <= '0;
      MEM_WDATA <= '0;
    end else begin
      MEM_REQ <= (st_nxt == ST_SAVE) || (st_nxt == ST_RESTORE);
      MEM_WE <= (st_nxt == ST_SAVE);
      MEM_ADDR <= phys(save_addr(base_r, idx_nxt));
      MEM_WDATA <= ctx_word(idx_nxt, snap_cr0_r, snap_cr4_r, snap_efer_r, snap_mode_r);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      RESTORE_CR0 <= '0;
      RESTORE_CR4 <= '0;
      RESTORE_EFER <= '0;
      RESTORE_MODE <= MME_REAL;
    end else if ((st_r == ST_RESTORE) && MEM_ACK) begin
      case (idx_r)
        0: RESTORE_CR0 <= MEM_RDATA;
        1: RESTORE_CR4 <= MEM_RDATA;
        2: RESTORE_EFER <= MEM_RDATA;
        default: RESTORE_MODE <= mme_opmode_e'(MEM_RDATA[1:0]);
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      RESTORE_LOAD <= 1'b0;
    end else begin
      RESTORE_LOAD <= resume_ok;
    end
  end

  always_comb begin
    in_mode_nxt = in_mode_r;
    if (enter) begin
      in_mode_nxt = 1'b1;
    end else if (resume_ok || leave_shut) begin
      in_mode_nxt = 1'b0;
    end
  end

  // Pin and flag are copies of the one mode bit
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      in_mode_r <= 1'b0;
      MGMT_ACTIVE_N <= 1'b1;
      MGMT_BUS_STATUS_FLAG <= 1'b0;
      MGMT_ACK_TRANSACTION <= 1'b0;
    end else begin
      in_mode_r <= in_mode_nxt;
      MGMT_ACTIVE_N <= !in_mode_nxt;
      MGMT_BUS_STATUS_FLAG <= in_mode_nxt;
      MGMT_ACK_TRANSACTION <= enter || resume_ok;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      FETCH_REDIRECT <= 1'b0;
      FETCH_ADDR <= '0;
    end else begin
      FETCH_REDIRECT <= enter;
      if (enter) FETCH_ADDR <= phys(base_r + `MME_HANDLER_OFS);
    end
  end

  // Lower-priority events lose the boundary to a pending request
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      OTHER_GRANT <= 3'h0;
    end else if (leave_shut && NMI_REQ) begin
      OTHER_GRANT <= 3'h1;
    end else if ((st_r == ST_IDLE) && INSN_BOUNDARY && !pend) begin
      OTHER_GRANT <= NMI_REQ ? 3'h1 : DBG_REQ ? 3'h2 : MASKABLE_IRQ_IN_REQ ? 3'h4 : 3'h0;
    end else begin
      OTHER_GRANT <= 3'h0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      INVALID_OPCODE_FAULT <= 1'b0;
    end else begin
      INVALID_OPCODE_FAULT <= RESUME_EXEC && !in_mode_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      SHUTDOWN <= 1'b0;
      SHUTDOWN_CYCLE <= 1'b0;
      INHIBIT_MASKABLE_IRQ_IN <= 1'b0;
      INHIBIT_ADDR_BIT20_MASK <= 1'b0;
    end else begin
      SHUTDOWN <= (st_nxt == ST_SHUTDN);
      SHUTDOWN_CYCLE <= resume_bad;
      INHIBIT_MASKABLE_IRQ_IN <= (st_nxt == ST_SHUTDN);
      INHIBIT_ADDR_BIT20_MASK <= (st_nxt == ST_SHUTDN);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      base_r <= `MME_BASE_RST;
      ctrl_r <= `MME_CTRL_RST;
    end else if (REG_WR) begin
      if (REG_ADDR == `MME_REG_BASE) base_r <= REG_WDATA;
      if (REG_ADDR == `MME_REG_CTRL) ctrl_r <= REG_WDATA & 32'h0000_0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      REG_RDATA <= '0;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        `MME_REG_BASE: REG_RDATA <= base_r;
        `MME_REG_CTRL: REG_RDATA <= ctrl_r;
        `MME_REG_STAT: REG_RDATA <= {22'h0, st_r, SHUTDOWN, pend, in_mode_r};
        default: REG_RDATA <= '0;
      endcase
    end else begin
      REG_RDATA <= '0;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  property p_boundary;
    $rose(st_r == ST_DRAIN) |-> $past(INSN_BOUNDARY) && $past(pend);
  endproperty
  a_boundary: assert property (p_boundary) else $error("entry off boundary");

  property p_drain;
    (st_r == ST_DRAIN) && !drained |=> (st_r == ST_DRAIN) && !MEM_REQ;
  endproperty
  a_drain: assert property (p_drain) else $error("save before drain");

  property p_fetch;
    enter |=> FETCH_REDIRECT && (FETCH_ADDR[31:0] == base_r + `MME_HANDLER_OFS);
  endproperty
  a_fetch: assert property (p_fetch) else $error("handler fetch address wrong");

  property p_save_area;
    MEM_REQ |-> (MEM_ADDR[31:0] - base_r) >= `MME_SAVE_LO &&
                (MEM_ADDR[31:0] - base_r) <= `MME_SAVE_HI;
  endproperty
  a_save_area: assert property (p_save_area) else $error("save outside area");

  property p_reset_base;
    !$past(RESETN) |-> base_r == `MME_BASE_RST;
  endproperty
  a_reset_base: assert property (p_reset_base) else $error("base reset value");

  property p_low4g;
    MEM_REQ |-> MEM_ADDR[PA_W-1:32] == '0;
  endproperty
  a_low4g: assert property (p_low4g) else $error("address above 4G");

  property p_notify;
    $changed(MGMT_BUS_STATUS_FLAG) && !$past(leave_shut) |-> MGMT_ACK_TRANSACTION
      && (MGMT_ACTIVE_N == !MGMT_BUS_STATUS_FLAG);
  endproperty
  a_notify: assert property (p_notify) else $error("mode change unannounced");

  property p_prio;
    take_smi |=> OTHER_GRANT == 3'h0;
  endproperty
  a_prio: assert property (p_prio) else $error("other event beat request");

  property p_ud;
    RESUME_EXEC && !in_mode_r |=> INVALID_OPCODE_FAULT ##1 !INVALID_OPCODE_FAULT[*1];
  endproperty
  a_ud: assert property (p_ud) else $error("no invalid opcode");

  property p_shut;
    resume_bad |=> SHUTDOWN && SHUTDOWN_CYCLE && INHIBIT_MASKABLE_IRQ_IN && INHIBIT_ADDR_BIT20_MASK && in_mode_r;
  endproperty
  a_shut: assert property (p_shut) else $error("bad state not shut down");

  c_entry: cover property (enter);
  c_resume: cover property (resume_ok);
  c_shut: cover property (resume_bad);
  c_latched: cover property ((st_r == ST_HANDLER) && pend);

endmodule : mme_ctrl

`default_nettype wire

// ===== testbench/mme_ram_model.sv
`timescale 1ns/1ps
`default_nettype none

module mme_ram_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [35:0] mem_addr,
  input wire mme_pkg::mme_word_t mem_wdata,
  input wire mme_pkg::mme_word_t base,
  input wire logic slow,
  output mme_pkg::mme_word_t mem_rdata,
  output logic mem_ack,
  output mme_pkg::mme_word_t miss_cnt
);
  import mme_pkg::*;
  mme_word_t mem [logic [35:0]];
  logic [1:0] wait_r;
  logic [35:0] ofs;
  assign ofs = mem_addr - {4'h0, base};
  // Write lands at the accepting edge, request still held there
  always @(posedge clk) begin
    if (mem_ack && mem_we) begin
      mem[mem_addr] = mem_wdata;
    end
  end
  // Never acks twice running, so a dropped request is not answered
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_ack <= 1'b0;
      wait_r <= 2'h0;
      miss_cnt <= 32'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && wait_r == 2'h0) begin
      mem_ack <= 1'b1;
      wait_r <= slow ? 2'h3 : 2'h0;
      mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_rdata;
      if (ofs < 36'h8000 || ofs > 36'hFFFF || mem_addr[35:32] != 4'h0) begin
        miss_cnt <= miss_cnt + 32'h1;
      end
    end else begin
      mem_ack <= 1'b0;
      wait_r <= (wait_r == 2'h0) ? 2'h0 : wait_r - 2'h1;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : mme_ram_model

`default_nettype wire

// ===== testbench/mme_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "mme_consts.svh"

module mme_ctrl_test;
  import mme_pkg::*;
  logic CLK, RESETN, MGMT_IRQ_N, APIC_MGMT_MSG, INSN_BOUNDARY, RETIRED_ALL, STORES_DONE;
  logic NMI_REQ, MASKABLE_IRQ_IN_REQ, DBG_REQ, INIT_REQ, RESUME_EXEC, MEM_ACK, REG_WR, REG_RD, slow;
  mme_word_t CUR_CR0, CUR_CR4, CUR_EFER, MEM_RDATA, REG_WDATA, REG_RDATA, MEM_WDATA;
  mme_word_t RESTORE_CR0, RESTORE_CR4, RESTORE_EFER, miss_cnt, base;
  mme_opmode_e CUR_MODE, RESTORE_MODE;
  logic [3:0] REG_ADDR;
  logic [35:0] MEM_ADDR, FETCH_ADDR;
  logic [2:0] OTHER_GRANT, gsum;
  logic MEM_REQ, MEM_WE, FETCH_REDIRECT, MGMT_ACTIVE_N, MGMT_BUS_STATUS_FLAG;
  logic MGMT_ACK_TRANSACTION, INVALID_OPCODE_FAULT, RESTORE_LOAD, SHUTDOWN, SHUTDOWN_CYCLE;
  logic INHIBIT_MASKABLE_IRQ_IN, INHIBIT_ADDR_BIT20_MASK, bad;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int k, it;
  logic [31:0] lfsr = 32'h48620FC2;
  mme_word_t cur [4];
  mme_word_t img [4];

  mme_ctrl #(.PA_W(36), .NWORDS(4)) i_mme_ctrl (.*);
  mme_ram_model i_mme_ram_model (.clk(CLK), .resetn(RESETN), .mem_req(MEM_REQ),
    .mem_we(MEM_WE), .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA), .base(base), .slow(slow),
    .mem_rdata(MEM_RDATA), .mem_ack(MEM_ACK), .miss_cnt(miss_cnt));

  initial CLK = 1'b0;
  always #20 CLK = ~CLK;
  always @(negedge CLK) gsum |= OTHER_GRANT;
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      final_report();
    end
  end

  function automatic logic [31:0] next_rand();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : next_rand

  // Reference model of the state checks made on resume
  function automatic bit exp_bad(int c0, int c4, int ef, int b, bit leg);
    return (c4 & 32'hFF80_0000) != 0 || (c0[`MME_CR0_PG] && !c0[`MME_CR0_PE])
      || (c0[`MME_CR0_NW] && !c0[`MME_CR0_CD]) || (c4[`MME_CR4_CTXID] && !ef[`MME_EFER_LMA])
      || (leg && (b & 32'h7FFF) != 0);
  endfunction : exp_bad

  task automatic cmp(input logic [35:0] got, input logic [35:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic final_report();
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  task automatic reg_wr(input logic [3:0] a, input mme_word_t d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, input mme_word_t e, input string w);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(negedge CLK);
    cmp(REG_RDATA, e, w);
  endtask : reg_rd

  task automatic msg_pulse();
    @(posedge CLK);
    APIC_MGMT_MSG <= 1'b1;
    @(posedge CLK);
    APIC_MGMT_MSG <= 1'b0;
  endtask : msg_pulse

  // Bounded wait for entry, successful exit or shutdown
  task automatic wait_evt();
    for (int i = 0; i < 400 && (FETCH_REDIRECT | RESTORE_LOAD | SHUTDOWN_CYCLE) !== 1'b1; i++)
      @(negedge CLK);
  endtask : wait_evt

  initial begin
    {MGMT_IRQ_N, APIC_MGMT_MSG, INSN_BOUNDARY, RETIRED_ALL, STORES_DONE} = 5'h10;
    {NMI_REQ, MASKABLE_IRQ_IN_REQ, DBG_REQ, INIT_REQ, RESUME_EXEC, REG_WR, REG_RD, slow} = 8'h00;
    {CUR_CR0, CUR_CR4, CUR_EFER, REG_WDATA} = '0;
    CUR_MODE = MME_REAL;
    REG_ADDR = 4'h0;
    base = `MME_BASE_RST;
    RESETN = 1'b0;
    repeat (5) @(posedge CLK);
    RESETN <= 1'b1;
    reg_rd(`MME_REG_BASE, 32'h0003_0000, "base reset");
    reg_rd(`MME_REG_CTRL, 32'h0, "ctrl reset");
    reg_rd(`MME_REG_STAT, 32'h8, "idle status");
    reg_wr(4'hC, next_rand());
    reg_rd(4'hC, 32'h0, "unmapped");
    cmp(MGMT_ACTIVE_N, 1'b1, "pin idle");
    for (k = 1; k < 8; k++) begin
      @(posedge CLK);
      {NMI_REQ, DBG_REQ, MASKABLE_IRQ_IN_REQ} <= k[2:0];
      INSN_BOUNDARY <= 1'b1;
      @(posedge CLK);
      {NMI_REQ, DBG_REQ, MASKABLE_IRQ_IN_REQ} <= 3'h0;
      INSN_BOUNDARY <= 1'b0;
      @(negedge CLK);
      repeat (3) if (OTHER_GRANT === 3'h0) @(negedge CLK);
      cmp(OTHER_GRANT, k[2] ? 3'h1 : (k[1] ? 3'h2 : 3'h4), "grant order");
    end
    @(posedge CLK);
    RESUME_EXEC <= 1'b1;
    @(posedge CLK);
    RESUME_EXEC <= 1'b0;
    @(negedge CLK);
    cmp(INVALID_OPCODE_FAULT, 1'b1, "resume outside");
    for (it = 0; it < 8; it++) begin
      base = (next_rand() & 32'h7FFF_8000) | ((it > 5) ? 32'h100 : 32'h0);
      reg_wr(`MME_REG_BASE, base);
      reg_wr(`MME_REG_CTRL, (it == 6) ? 32'h1 : 32'h0);
      for (k = 0; k < 4; k++) cur[k] = next_rand();
      cur[3] = 32'(2'(cur[3] % 3));
      @(posedge CLK);
      {CUR_CR0, CUR_CR4, CUR_EFER} <= {cur[0], cur[1], cur[2]};
      CUR_MODE <= mme_opmode_e'(cur[3][1:0]);
      {RETIRED_ALL, STORES_DONE} <= 2'h0;
      slow <= (it == 7);
      if (it % 2 == 0) MGMT_IRQ_N <= 1'b0;
      else if (it != 1) msg_pulse();
      repeat (8) @(negedge CLK);
      cmp(MEM_REQ, 1'b0, "no boundary");
      @(posedge CLK);
      INSN_BOUNDARY <= 1'b1;
      {NMI_REQ, DBG_REQ, MASKABLE_IRQ_IN_REQ} <= 3'h7;
      gsum = 3'h0;
      repeat (6) @(negedge CLK);
      cmp(MEM_REQ, 1'b0, "undrained");
      @(posedge CLK);
      {RETIRED_ALL, STORES_DONE} <= 2'h3;
      wait_evt();
      cmp(FETCH_REDIRECT, 1'b1, "entry");
      cmp(FETCH_ADDR, {4'h0, base} + 36'h8000, "handler fetch");
      cmp({MGMT_ACTIVE_N, MGMT_BUS_STATUS_FLAG, MGMT_ACK_TRANSACTION}, 3'h3, "enter");
      cmp(gsum, 3'h0, "others held off");
      @(posedge CLK);
      {NMI_REQ, DBG_REQ, MASKABLE_IRQ_IN_REQ} <= 3'h0;
      MGMT_IRQ_N <= 1'b1;
      for (k = 0; k < 4; k++) begin
        img[k] = i_mme_ram_model.mem[{4'h0, base} + 36'hFE00 + 36'(4 * k)];
        cmp((k == 3) ? 32'(img[k][1:0]) : img[k], cur[k], "saved word");
      end
      if (it == 0) begin
        msg_pulse();
        msg_pulse();
        reg_rd(`MME_REG_STAT, 32'h43, "one latched");
        cmp(MEM_REQ, 1'b0, "no nesting");
      end
      img[0] = next_rand() & 32'h5FFF_FFFF;
      img[1] = next_rand() & 32'h0001_FFFF;
      img[2] = next_rand();
      img[3] = 32'(2'(next_rand() % 3));
      case (it)
        2: img[1] |= 32'h0080_0000;
        3: img[0] = (img[0] | 32'h8000_0000) & ~32'h1;
        4: img[0] = (img[0] | 32'h2000_0000) & ~32'h4000_0000;
        5: begin
          img[1] |= 32'h0002_0000;
          img[2] &= ~32'h400;
        end
        default: ;
      endcase
      for (k = 0; k < 4; k++) i_mme_ram_model.mem[{4'h0, base} + 36'hFE00 + 36'(4 * k)] = img[k];
      bad = exp_bad(img[0], img[1], img[2], base, it == 6);
      @(posedge CLK);
      RESUME_EXEC <= 1'b1;
      INSN_BOUNDARY <= 1'b0;
      @(posedge CLK);
      RESUME_EXEC <= 1'b0;
      wait_evt();
      cmp(SHUTDOWN_CYCLE, bad, "state check");
      if (!bad) begin
        cmp({RESTORE_LOAD, RESTORE_CR0}, {1'b1, img[0]}, "reload cr0");
        cmp(RESTORE_CR4, img[1], "reload cr4");
        cmp(RESTORE_EFER, img[2], "reload efer");
        cmp(RESTORE_MODE, img[3][1:0], "mode back");
        cmp({MGMT_ACTIVE_N, MGMT_BUS_STATUS_FLAG, MGMT_ACK_TRANSACTION}, 3'h5, "exit");
      end else begin
        cmp({SHUTDOWN, INHIBIT_MASKABLE_IRQ_IN, INHIBIT_ADDR_BIT20_MASK, RESTORE_LOAD}, 4'hE, "halted");
        msg_pulse();
        repeat (6) @(negedge CLK);
        cmp(MEM_REQ | FETCH_REDIRECT, 1'b0, "no work halted");
        @(posedge CLK);
        NMI_REQ <= 1'b1;
        @(posedge CLK);
        NMI_REQ <= 1'b0;
        for (k = 0; k < 8 && SHUTDOWN !== 1'b0; k++) @(negedge CLK);
        cmp({SHUTDOWN, MGMT_ACTIVE_N}, 2'h1, "leave halt");
      end
    end
    cmp(miss_cnt, 32'h0, "decode range");
    final_report();
  end
endmodule : mme_ctrl_test

`default_nettype wire
